// ---- hdl/ufcfn_top.sv ----
// USB function control register and frame number registers.
// Assumes an 8-bit register port and SIE event inputs on the system clock.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module ufcfn_top #(
  parameter int unsigned PSEUDO_FRAME_CYCLES =
    ufcfn_pkg::PSEUDO_FRAME_CYCLES,
  parameter int unsigned PSEUDO_CNT_W = ufcfn_pkg::PSEUDO_CNT_W
) (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RST_B_IN,
  input  wire logic [15:0] REG_ADDR_IN,
  input  wire logic [7:0]  REG_WDATA_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic        REG_RD_IN,
  output var  logic [7:0]  REG_RDATA_OUT,
  input  wire logic        BUS_RESET_IN,
  input  wire logic        SOF_VALID_IN,
  input  wire logic [10:0] SOF_FRAME_IN,
  input  wire logic        FRAME_LOCKED_IN,
  input  wire logic        SHADOW_WR_IN,
  input  wire logic        SHADOW_WDATA_IN,
  output var  logic        ROM_SHADOW_SELECT_OUT,
  output var  logic        DPLUS_PULLUP_OUT,
  output var  logic        DPLUS_PULLUP_OE_OUT,
  output var  logic        FUNCTION_RESPOND_ENABLE_OUT,
  output var  logic        REMOTE_WAKEUP_REQUEST_OUT,
  output var  logic        RESET_OUT,
  output var  logic        CHIP_RESET_OUT,
  output var  logic        PSEUDO_FRAME_TICK_OUT
);

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  logic        attach_reg;
  logic        attach_next;
  logic        respond_reg;
  logic        respond_next;
  logic        wakeup_reg;
  logic        wakeup_next;
  logic        scope_reg;
  logic        scope_next;
  logic        confirm_reg;
  logic        confirm_next;
  logic        shadow_reg;
  logic        shadow_next;
  logic [10:0] frame_reg;
  logic [10:0] frame_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic        reset_out_reg;
  logic        reset_out_next;
  logic        pseudo_tick;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire sel_ctl  = (REG_ADDR_IN == ufcfn_pkg::ADDR_CTL);
  wire sel_low  = (REG_ADDR_IN == ufcfn_pkg::ADDR_FRAME_LOW);
  wire sel_high = (REG_ADDR_IN == ufcfn_pkg::ADDR_FRAME_HIGH);
  wire ctl_wr   = REG_WR_IN && sel_ctl;

  // Whole-scope bus reset: the rest of the chip restarts too
  wire scope_reset = BUS_RESET_IN && scope_reg;

  wire [7:0] ctl_view = {attach_reg, respond_reg, wakeup_reg, scope_reg,
                         3'h0, confirm_reg};
  wire [7:0] low_view  = frame_reg[ufcfn_pkg::FRAME_LOW_W-1:0];
  wire [7:0] high_view = {ufcfn_pkg::FRAME_PAD,
                          frame_reg[ufcfn_pkg::FRAME_W-1:
                                    ufcfn_pkg::FRAME_LOW_W]};

  // ----------------------------------------------------------------
  // Control register next values
  // ----------------------------------------------------------------
  // Attach, scope and confirm ignore bus reset by design
  assign attach_next  = ctl_wr ?
    REG_WDATA_IN[ufcfn_pkg::CTL_ATTACH_BIT] : attach_reg;
  assign scope_next   = ctl_wr ?
    REG_WDATA_IN[ufcfn_pkg::CTL_SCOPE_BIT] : scope_reg;
  assign confirm_next = ctl_wr ?
    REG_WDATA_IN[ufcfn_pkg::CTL_CONFIRM_BIT] : confirm_reg;
  // Bus reset (whole-scope only, for wake-up) beats a same-cycle firmware write
  assign respond_next = BUS_RESET_IN ? 1'b0 :
    ctl_wr ? REG_WDATA_IN[ufcfn_pkg::CTL_RESPOND_BIT] : respond_reg;
  assign wakeup_next  = scope_reset ? 1'b0 :
    ctl_wr ? REG_WDATA_IN[ufcfn_pkg::CTL_WAKEUP_BIT] : wakeup_reg;

  // Spurious clears are dropped silently, sets always land
  assign shadow_next = (SHADOW_WR_IN && (SHADOW_WDATA_IN || confirm_reg)) ?
    SHADOW_WDATA_IN : shadow_reg;

  assign reset_out_next = scope_reset;

  // ----------------------------------------------------------------
  // Frame count
  // ----------------------------------------------------------------
  // Host value outranks a local tick landing in the same cycle
  assign frame_next = scope_reset  ? ufcfn_pkg::FRAME_RESET :
                      SOF_VALID_IN ? SOF_FRAME_IN :
                      pseudo_tick  ? frame_reg + ufcfn_pkg::FRAME_STEP :
                      frame_reg;

  ufcfn_frame_timer #(
    .PERIOD_CYCLES (PSEUDO_FRAME_CYCLES),
    .CNT_W         (PSEUDO_CNT_W)
  ) u_frame_timer (
    .clk_in    (SYS_CLK_IN),
    .rst_b_in  (RST_B_IN),
    .sof_in    (SOF_VALID_IN),
    .locked_in (FRAME_LOCKED_IN),
    .tick_out  (pseudo_tick)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Unmapped addresses and idle cycles read as zero
  assign rdata_next = !REG_RD_IN ? ufcfn_pkg::RDATA_IDLE :
                      sel_ctl    ? ctl_view :
                      sel_low    ? low_view :
                      sel_high   ? high_view : ufcfn_pkg::RDATA_IDLE;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      attach_reg    <= ufcfn_pkg::CTL_RESET[ufcfn_pkg::CTL_ATTACH_BIT];
      respond_reg   <= ufcfn_pkg::CTL_RESET[ufcfn_pkg::CTL_RESPOND_BIT];
      wakeup_reg    <= ufcfn_pkg::CTL_RESET[ufcfn_pkg::CTL_WAKEUP_BIT];
      scope_reg     <= ufcfn_pkg::CTL_RESET[ufcfn_pkg::CTL_SCOPE_BIT];
      confirm_reg   <= ufcfn_pkg::CTL_RESET[ufcfn_pkg::CTL_CONFIRM_BIT];
      shadow_reg    <= ufcfn_pkg::SHADOW_RESET;
      frame_reg     <= ufcfn_pkg::FRAME_RESET;
      rdata_reg     <= ufcfn_pkg::RDATA_IDLE;
      reset_out_reg <= 1'b0;
    end else begin
      attach_reg    <= attach_next;
      respond_reg   <= respond_next;
      wakeup_reg    <= wakeup_next;
      scope_reg     <= scope_next;
      confirm_reg   <= confirm_next;
      shadow_reg    <= shadow_next;
      frame_reg     <= frame_next;
      rdata_reg     <= rdata_next;
      reset_out_reg <= reset_out_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign REG_RDATA_OUT               = rdata_reg;
  assign DPLUS_PULLUP_OUT            = attach_reg;
  assign DPLUS_PULLUP_OE_OUT         = attach_reg;
  assign FUNCTION_RESPOND_ENABLE_OUT = respond_reg;
  assign REMOTE_WAKEUP_REQUEST_OUT   = wakeup_reg;
  assign RESET_OUT                   = reset_out_reg;
  assign CHIP_RESET_OUT              = reset_out_reg;
  assign ROM_SHADOW_SELECT_OUT       = shadow_reg;
  assign PSEUDO_FRAME_TICK_OUT       = pseudo_tick;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  pullup_drive_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    ctl_wr && REG_WDATA_IN[ufcfn_pkg::CTL_ATTACH_BIT]
    |=> DPLUS_PULLUP_OE_OUT && DPLUS_PULLUP_OUT)
    else $error("pullup not driven after attach");

  pullup_release_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    ctl_wr && !REG_WDATA_IN[ufcfn_pkg::CTL_ATTACH_BIT]
    |=> !DPLUS_PULLUP_OE_OUT)
    else $error("pullup still driven after detach");

  attach_keep_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    BUS_RESET_IN && !ctl_wr |=> $stable(DPLUS_PULLUP_OE_OUT))
    else $error("attach changed by bus reset");

  respond_set_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    ctl_wr && !BUS_RESET_IN |=>
    FUNCTION_RESPOND_ENABLE_OUT ==
      $past(REG_WDATA_IN[ufcfn_pkg::CTL_RESPOND_BIT]))
    else $error("respond enable not written");

  respond_clear_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    BUS_RESET_IN |=> !FUNCTION_RESPOND_ENABLE_OUT)
    else $error("respond enable kept over bus reset");

  wakeup_req_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    ctl_wr && !scope_reset && REG_WDATA_IN[ufcfn_pkg::CTL_WAKEUP_BIT]
    |=> REMOTE_WAKEUP_REQUEST_OUT)
    else $error("wake-up request missing");

  scope_reset_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    scope_reset && !ctl_wr |=> CHIP_RESET_OUT && !REMOTE_WAKEUP_REQUEST_OUT
    && $stable(ROM_SHADOW_SELECT_OUT) && scope_reg)
    else $error("scope reset wrong");

  reset_pin_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    RESET_OUT == $past(BUS_RESET_IN && scope_reg))
    else $error("reset pin does not follow bus reset");

  shadow_guard_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    SHADOW_WR_IN && !SHADOW_WDATA_IN && !confirm_reg
    |=> $stable(ROM_SHADOW_SELECT_OUT))
    else $error("shadow cleared without confirm");

  high_read_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    REG_RD_IN && sel_high |=>
    REG_RDATA_OUT == {ufcfn_pkg::FRAME_PAD, $past(frame_reg[10:8])})
    else $error("frame high read wrong");

  sof_load_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    SOF_VALID_IN && !scope_reset |=> frame_reg == $past(SOF_FRAME_IN))
    else $error("frame count not loaded from packet");

  tick_step_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    pseudo_tick && !SOF_VALID_IN && !scope_reset
    |=> frame_reg == $past(frame_reg) + ufcfn_pkg::FRAME_STEP)
    else $error("frame count missed a pseudo tick");

  reserved_zero_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    REG_RD_IN && sel_ctl |=> REG_RDATA_OUT[3:1] == 3'h0)
    else $error("reserved control bits not zero");

  low_read_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    REG_RD_IN && sel_low |=>
    REG_RDATA_OUT == $past(frame_reg[ufcfn_pkg::FRAME_LOW_W-1:0]))
    else $error("frame low read wrong");

  unmapped_read_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    REG_RD_IN && !sel_ctl && !sel_low && !sel_high |=>
    REG_RDATA_OUT == ufcfn_pkg::RDATA_IDLE)
    else $error("unmapped read not zero");

  respond_hold_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    !ctl_wr && !BUS_RESET_IN |=> $stable(FUNCTION_RESPOND_ENABLE_OUT))
    else $error("respond enable changed by itself");

  wakeup_hold_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    !ctl_wr && !scope_reset |=> $stable(REMOTE_WAKEUP_REQUEST_OUT))
    else $error("wake-up request cleared by hardware");

  frame_hold_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    !SOF_VALID_IN && !pseudo_tick && !scope_reset |=> $stable(frame_reg))
    else $error("frame count moved without an event");

  attach_cov: cover property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    ctl_wr ##1 DPLUS_PULLUP_OE_OUT);

  scope_reset_cov: cover property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    scope_reset ##1 RESET_OUT);

  tick_cov: cover property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    pseudo_tick && !SOF_VALID_IN);

  shadow_clear_cov: cover property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    SHADOW_WR_IN && !SHADOW_WDATA_IN && confirm_reg && shadow_reg);

  narrow_reset_cov: cover property (
    @(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    BUS_RESET_IN && !scope_reg ##1 !FUNCTION_RESPOND_ENABLE_OUT);

endmodule

`default_nettype wire

// ---- hdl/ufcfn_pkg.sv ----
// Constants for the USB function control and frame number block.
// Assumes a 10 MHz system clock and an 8-bit register port.
package ufcfn_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_FRAME_HIGH = 16'hFFFA;
  localparam logic [15:0] ADDR_FRAME_LOW  = 16'hFFFB;
  localparam logic [15:0] ADDR_CTL        = 16'hFFFC;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int unsigned CTL_ATTACH_BIT  = 7;
  localparam int unsigned CTL_RESPOND_BIT = 6;
  localparam int unsigned CTL_WAKEUP_BIT  = 5;
  localparam int unsigned CTL_SCOPE_BIT   = 4;
  localparam int unsigned CTL_CONFIRM_BIT = 0;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned ADDR_W          = 16;
  localparam int unsigned FRAME_W         = 11;
  localparam int unsigned FRAME_LOW_W     = 8;
  localparam int unsigned FRAME_HIGH_W    = 3;
  localparam int unsigned FRAME_PAD_W     = 5;
  localparam logic [7:0]  CTL_RESET       = 8'h00;
  localparam logic [7:0]  RDATA_IDLE      = 8'h00;
  localparam logic [10:0] FRAME_RESET     = 11'h000;
  localparam logic [10:0] FRAME_STEP      = 11'h001;
  localparam logic [4:0]  FRAME_PAD       = 5'h00;
  localparam logic        SHADOW_RESET    = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned PSEUDO_FRAME_NS = 1000000;
  localparam int unsigned PSEUDO_FRAME_CYCLES =
    PSEUDO_FRAME_NS / CLK_PERIOD_NS;
  localparam int unsigned PSEUDO_CNT_W    = 14;

endpackage

// ---- hdl/ufcfn_frame_timer.sv ----
// Local frame timer that makes pseudo frame ticks when unlocked.
// Assumes a start-of-frame pulse synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none

module ufcfn_frame_timer #(
  parameter int unsigned PERIOD_CYCLES = ufcfn_pkg::PSEUDO_FRAME_CYCLES,
  parameter int unsigned CNT_W         = ufcfn_pkg::PSEUDO_CNT_W
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic sof_in,
  input  wire logic locked_in,
  output var  logic tick_out
);

  // ----------------------------------------------------------------
  // Period counter
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PERIOD_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             wrap;
  logic             tick_next;

  // Host frame restarts the phase so ticks stay aligned to the host
  assign wrap      = (cnt_reg == CNT_LAST);
  assign cnt_next  = (sof_in || wrap) ? CNT_ZERO : cnt_reg + CNT_ONE;
  assign tick_next = wrap && !sof_in && !locked_in;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_reg  <= CNT_ZERO;
      tick_out <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_out <= tick_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  tick_period_a: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    tick_out |-> $past(cnt_reg) == CNT_LAST && cnt_reg == CNT_ZERO)
    else $error("pseudo tick off the period end");

  tick_locked_a: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    $past(locked_in) |-> !tick_out)
    else $error("pseudo tick while locked");

endmodule

`default_nettype wire

// ---- tb/ufcfn_sie_model.sv ----
// SIE-side model: start-of-frame strobes, bus reset and frame lock.
// Assumes its tasks are called by the bench just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module ufcfn_sie_model (
  input  wire logic        clk_in,
  output var  logic        sof_valid_out,
  output var  logic [10:0] sof_frame_out,
  output var  logic        bus_reset_out,
  output var  logic        locked_out
);
  initial begin
    sof_valid_out = 1'b0;
    sof_frame_out = 11'h000;
    bus_reset_out = 1'b0;
    locked_out    = 1'b1;
  end

  // Field is junk outside the strobe, so a stale value cannot pass
  task automatic send_sof(input logic [10:0] f);
    @(posedge clk_in);
    sof_valid_out <= 1'b1;
    sof_frame_out <= f;
    @(posedge clk_in);
    sof_valid_out <= 1'b0;
    sof_frame_out <= ~f;
    #1;
  endtask

  task automatic bus_reset(input int n);
    @(posedge clk_in);
    bus_reset_out <= 1'b1;
    repeat (n) @(posedge clk_in);
    bus_reset_out <= 1'b0;
    #1;
  endtask

  task automatic set_lock(input logic l);
    @(posedge clk_in);
    locked_out <= l;
    #1;
  endtask
endmodule

`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the USB control and frame number block.
// Assumes the SIE model beside it and a short pseudo frame period.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam int unsigned PER = 20;
  logic        clk;
  logic        rst_b;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic        sh_wr;
  logic        sh_wd;
  logic        rd_seen = 1'b0;
  logic [7:0]  exp_q[$];
  int          err_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          seed = 32'hBADE;
  int          t1, t2;
  logic [31:0] f;
  wire logic [7:0]  rdata;
  wire logic        sof_v, bus_rst, locked, shadow, pu, pu_oe;
  wire logic        respond, wake, rst_out, chip_rst, tick;
  wire logic [10:0] sof_f;

  always #50 clk = ~clk;

  ufcfn_sie_model u_sie (.clk_in(clk), .sof_valid_out(sof_v),
    .sof_frame_out(sof_f), .bus_reset_out(bus_rst), .locked_out(locked));

  ufcfn_top #(.PSEUDO_FRAME_CYCLES(PER), .PSEUDO_CNT_W(8)) DUT (
    .SYS_CLK_IN(clk), .RST_B_IN(rst_b), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_RDATA_OUT(rdata), .BUS_RESET_IN(bus_rst), .SOF_VALID_IN(sof_v),
    .SOF_FRAME_IN(sof_f), .FRAME_LOCKED_IN(locked),
    .SHADOW_WR_IN(sh_wr), .SHADOW_WDATA_IN(sh_wd),
    .ROM_SHADOW_SELECT_OUT(shadow), .DPLUS_PULLUP_OUT(pu),
    .DPLUS_PULLUP_OE_OUT(pu_oe), .FUNCTION_RESPOND_ENABLE_OUT(respond),
    .REMOTE_WAKEUP_REQUEST_OUT(wake), .RESET_OUT(rst_out),
    .CHIP_RESET_OUT(chip_rst), .PSEUDO_FRAME_TICK_OUT(tick));

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [10:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (err_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd   <= 1'b0;
    #1;
  endtask

  task automatic sh_write(input logic v);
    @(posedge clk);
    sh_wr <= 1'b1;
    sh_wd <= v;
    @(posedge clk);
    sh_wr <= 1'b0;
    #1;
  endtask

  // Bounded wait so a dead timer shows up as a mismatch
  task automatic wait_tick(output int t);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (tick !== 1'b1 && n < 200);
    chk("tick_seen", {10'h000, tick}, 11'h001);
    t = cyc;
  endtask

  // ----------------------------------------------------------------
  // Read data monitor and timeout
  // ----------------------------------------------------------------
  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) begin
    if (rd_seen) begin
      chk("rdata", {3'h0, rdata}, {3'h0, exp_q.pop_front()});
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    clk   = 1'b0;
    rst_b = 1'b0;
    addr  = 16'h0000;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
    sh_wr = 1'b0;
    sh_wd = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk("pullup_oe", {10'h000, pu_oe}, 11'h000);
    rd_reg(ufcfn_pkg::ADDR_FRAME_HIGH, 8'h00);
    rd_reg(ufcfn_pkg::ADDR_FRAME_LOW, 8'h00);
    rd_reg(ufcfn_pkg::ADDR_CTL, 8'h00);
    rd_reg(16'h1234, 8'h00);
    wr_reg(ufcfn_pkg::ADDR_CTL, 8'hFF);
    chk("pullup_oe", {10'h000, pu_oe}, 11'h001);
    chk("pullup", {10'h000, pu}, 11'h001);
    chk("respond", {10'h000, respond}, 11'h001);
    chk("wakeup", {10'h000, wake}, 11'h001);
    rd_reg(ufcfn_pkg::ADDR_CTL, 8'hF1);
    wr_reg(ufcfn_pkg::ADDR_CTL, 8'h41);
    chk("wakeup", {10'h000, wake}, 11'h000);
    chk("pullup_oe", {10'h000, pu_oe}, 11'h000);
    wr_reg(ufcfn_pkg::ADDR_FRAME_HIGH, 8'hFF);
    wr_reg(ufcfn_pkg::ADDR_FRAME_LOW, 8'hFF);
    rd_reg(ufcfn_pkg::ADDR_FRAME_HIGH, 8'h00);
    rd_reg(ufcfn_pkg::ADDR_FRAME_LOW, 8'h00);
    // Bus reset with narrow scope
    wr_reg(ufcfn_pkg::ADDR_CTL, 8'hC1);
    fork
      u_sie.bus_reset(3);
      begin
        repeat (2) @(posedge clk);
        #1;
        chk("reset_out", {10'h000, rst_out}, 11'h000);
      end
    join
    chk("respond", {10'h000, respond}, 11'h000);
    chk("pullup_oe", {10'h000, pu_oe}, 11'h001);
    rd_reg(ufcfn_pkg::ADDR_CTL, 8'h81);
    // Shadow clear guard
    sh_write(1'b1);
    wr_reg(ufcfn_pkg::ADDR_CTL, 8'h80);
    sh_write(1'b0);
    chk("shadow", {10'h000, shadow}, 11'h001);
    wr_reg(ufcfn_pkg::ADDR_CTL, 8'h81);
    sh_write(1'b0);
    chk("shadow", {10'h000, shadow}, 11'h000);
    sh_write(1'b1);
    // Bus reset with full scope
    wr_reg(ufcfn_pkg::ADDR_CTL, 8'hF1);
    u_sie.send_sof(11'h5A5);
    fork
      u_sie.bus_reset(3);
      begin
        repeat (2) @(posedge clk);
        #1;
        chk("reset_out", {10'h000, rst_out}, 11'h001);
        chk("chip_reset", {10'h000, chip_rst}, 11'h001);
      end
    join
    repeat (2) @(posedge clk);
    #1;
    chk("reset_out", {10'h000, rst_out}, 11'h000);
    chk("shadow", {10'h000, shadow}, 11'h001);
    rd_reg(ufcfn_pkg::ADDR_CTL, 8'h91);
    rd_reg(ufcfn_pkg::ADDR_FRAME_LOW, 8'h00);
    wr_reg(ufcfn_pkg::ADDR_CTL, 8'h81);
    // Host frame numbers
    for (int i = 0; i < 4; i++) begin
      f = $random(seed);
      u_sie.send_sof(f[10:0]);
      rd_reg(ufcfn_pkg::ADDR_FRAME_LOW, f[7:0]);
      rd_reg(ufcfn_pkg::ADDR_FRAME_HIGH, {5'h00, f[10:8]});
    end
    // Free-running frames, including the 11-bit wrap
    u_sie.send_sof(11'h7FF);
    u_sie.set_lock(1'b0);
    wait_tick(t1);
    rd_reg(ufcfn_pkg::ADDR_FRAME_LOW, 8'h00);
    rd_reg(ufcfn_pkg::ADDR_FRAME_HIGH, 8'h00);
    wait_tick(t2);
    chk("tick_period", 11'(t2 - t1), 11'(PER));
    rd_reg(ufcfn_pkg::ADDR_FRAME_LOW, 8'h01);
    u_sie.set_lock(1'b1);
    repeat (3 * PER) begin
      @(posedge clk);
      #1;
      chk("tick_locked", {10'h000, tick}, 11'h000);
    end
    repeat (4) @(posedge clk);
    give_verdict();
  end
endmodule

`default_nettype wire
